//--- hisl_cfg.svh
// Offsets, field positions, reset values and patterns of the host interrupt status logic.
`ifndef HISL_CFG_SVH
`define HISL_CFG_SVH
`define HISL_OFF_STATUS      8'h92
`define HISL_OFF_ENABLE      8'h90
`define HISL_OFF_THRESH      8'h9C
`define HISL_STATUS_RST      16'h0000
`define HISL_ENABLE_RST      16'h0000
`define HISL_THRESH_RST      16'h0000
`define HISL_W1C_MASK        16'hEB40
`define HISL_WAKE_MASK       16'h003C
`define HISL_ENABLE_MASK     16'hEB7D
`define HISL_RSVD_MASK       16'h1483
`define HISL_BIT_LINK        15
`define HISL_BIT_TXDONE      14
`define HISL_BIT_RXRDY       13
`define HISL_BIT_OVR         11
`define HISL_BIT_TXSTOP      9
`define HISL_BIT_RXSTOP      8
`define HISL_BIT_TXSPACE     6
`define HISL_BIT_WFRAME      5
`define HISL_BIT_MAGIC       4
`define HISL_BIT_LINKUP      3
`define HISL_BIT_ENERGY      2
`define HISL_PME_WFRAME      4'h8
`define HISL_PME_MAGIC       4'h4
`define HISL_PME_LINKUP      4'h2
`define HISL_PME_ENERGY      4'h1
`endif

//--- hisl_host_model.sv
// Host model that drives the register strobes of the interrupt block.
`timescale 1ns/1ns
// ==========
// Host bus
module hisl_host_model (
  input  wire logic        clock,
  input  wire logic [15:0] reg_rdata,
  output logic      [7:0]  reg_addr = 8'h00,
  output logic             reg_wr = 1'b0,
  output logic             reg_rd = 1'b0,
  output logic      [15:0] reg_wdata = 16'hFFFF
);
  // Idle data is inverted so a stale word never looks like a fresh one.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
endmodule // hisl_host_model

//--- hisl_pkg.sv
// Types of the host interrupt status logic.
package hisl_pkg;
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] enable;
    logic [15:0] thresh;
    logic [15:0] rdata;
    logic        link_up;
    logic        irq;
  } hisl_state_t;
endpackage

//--- hisl_top.sv
// Interrupt status, enable and receive threshold registers with the interrupt pin.
`timescale 1ns/1ns
`include "hisl_cfg.svh"

// Behaviour
// - Interrupt pin asserts when flag and enable set.
// - Reads keep flags; write one clears non-wake flag.
// - Link change flag on any link transition.
// - Transmit done flag on frame sent.
// - Receive ready flag on complete frame queued.
// - Overrun flag on receive overrun event.
// - Transmit stopped flag on transmit halt.
// - Receive stopped flag on receive halt.
// - Transmit space flag when space available.
// - Wake frame flag cleared by pattern 1000.
// - Magic flag cleared by pattern 0100.
// - Link-up wake flag cleared by 0010.
// - Energy wake flag cleared by 0001.
// - Frame count at threshold raises receive ready.
// - Byte count above threshold raises receive ready.
// - Register reports queued frame total, resets zero.
// - Enable bit per flag gates the pin.
module hisl_top #(
  parameter int ADDR_W     = 8,
  parameter int BYTE_CNT_W = 16
) (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [15:0]           reg_wdata,
  output logic      [15:0]           reg_rdata,
  input  wire logic                  link_up_in,
  input  wire logic                  tx_frame_done,
  input  wire logic                  rx_frame_done,
  input  wire logic                  rx_overrun,
  input  wire logic                  tx_stopped,
  input  wire logic                  rx_stopped,
  input  wire logic                  tx_space_avail,
  input  wire logic                  wake_frame_det,
  input  wire logic                  magic_det,
  input  wire logic                  linkup_wake_det,
  input  wire logic                  energy_det,
  input  wire logic                  pme_wr,
  input  wire logic [3:0]            pme_event_code,
  input  wire logic                  frame_thr_en,
  input  wire logic                  byte_thr_en,
  input  wire logic [7:0]            queue_frame_count,
  input  wire logic [BYTE_CNT_W-1:0] queue_byte_count,
  output logic                       irq_n
);

  // ======================================================================
  // Parameter checks
  // Every register field sits at a fixed bit, so only the bus address and the byte counter
  // may change width.
  if ((ADDR_W < 8) || (ADDR_W > 16)) begin : g_bad_addr
    $error("ADDR_W must lie between 8 and 16");
  end
  if ((BYTE_CNT_W < 8) || (BYTE_CNT_W > 32)) begin : g_bad_bytes
    $error("BYTE_CNT_W must lie between 8 and 32");
  end

  // ======================================================================
  // State and decode
  localparam logic [15:0] FLAG_MASK = `HISL_W1C_MASK | `HISL_WAKE_MASK;

  hisl_pkg::hisl_state_t st_r;
  hisl_pkg::hisl_state_t st_nxt;
  logic                  hit_status;
  logic                  hit_enable;
  logic                  hit_thresh;
  logic                  wr_status;
  logic                  wr_enable;
  logic                  wr_thresh;
  logic                  link_edge;
  logic                  frame_thr_hit;
  logic                  byte_thr_hit;
  logic [BYTE_CNT_W-1:0] byte_thr_ext;
  logic [15:0]           set_v;
  logic [15:0]           pme_clr_v;
  logic [15:0]           clr_v;
  logic [15:0]           flag_nxt;

  assign hit_status = reg_addr == ADDR_W'(`HISL_OFF_STATUS);
  assign hit_enable = reg_addr == ADDR_W'(`HISL_OFF_ENABLE);
  assign hit_thresh = reg_addr == ADDR_W'(`HISL_OFF_THRESH);
  assign wr_status  = reg_wr && hit_status;
  assign wr_enable  = reg_wr && hit_enable;
  assign wr_thresh  = reg_wr && hit_thresh;

  // ======================================================================
  // Event sources
  // Threshold triggers are level driven so a full queue keeps the flag coming back.
  assign link_edge     = link_up_in != st_r.link_up;
  assign byte_thr_ext  = BYTE_CNT_W'(st_r.thresh[15:8]);
  assign frame_thr_hit = frame_thr_en && (queue_frame_count >= st_r.thresh[7:0]);
  assign byte_thr_hit  = byte_thr_en && (queue_byte_count > byte_thr_ext);

  assign set_v[`HISL_BIT_LINK]    = link_edge;
  assign set_v[`HISL_BIT_TXDONE]  = tx_frame_done;
  assign set_v[`HISL_BIT_RXRDY]   = rx_frame_done || frame_thr_hit || byte_thr_hit;
  assign set_v[12]                = 1'h0;
  assign set_v[`HISL_BIT_OVR]     = rx_overrun;
  assign set_v[10]                = 1'h0;
  assign set_v[`HISL_BIT_TXSTOP]  = tx_stopped;
  assign set_v[`HISL_BIT_RXSTOP]  = rx_stopped;
  assign set_v[7]                 = 1'h0;
  assign set_v[`HISL_BIT_TXSPACE] = tx_space_avail;
  assign set_v[`HISL_BIT_WFRAME]  = wake_frame_det;
  assign set_v[`HISL_BIT_MAGIC]   = magic_det;
  assign set_v[`HISL_BIT_LINKUP]  = linkup_wake_det;
  assign set_v[`HISL_BIT_ENERGY]  = energy_det;
  assign set_v[1:0]               = 2'h0;

  // ======================================================================
  // Clear sources
  // Wake flags ignore the status write and clear only by their own power event code.
  assign pme_clr_v[15:6] = 10'h000;
  assign pme_clr_v[`HISL_BIT_WFRAME] = pme_wr && (pme_event_code == `HISL_PME_WFRAME);
  assign pme_clr_v[`HISL_BIT_MAGIC]  = pme_wr && (pme_event_code == `HISL_PME_MAGIC);
  assign pme_clr_v[`HISL_BIT_LINKUP] = pme_wr && (pme_event_code == `HISL_PME_LINKUP);
  assign pme_clr_v[`HISL_BIT_ENERGY] = pme_wr && (pme_event_code == `HISL_PME_ENERGY);
  assign pme_clr_v[1:0]  = 2'h0;
  assign clr_v = (wr_status ? (reg_wdata & `HISL_W1C_MASK) : 16'h0000) | pme_clr_v;

  // ======================================================================
  // Flag update
  for (genvar b = 0; b < 16; b++) begin : g_flag
    if (FLAG_MASK[b]) begin : g_live
      // A new event in the clearing cycle wins so no event is lost.
      assign flag_nxt[b] = (st_r.status[b] && !clr_v[b]) || set_v[b];
    end else begin : g_rsvd
      assign flag_nxt[b] = 1'h0;
    end
  end

  always_comb begin
    st_nxt         = st_r;
    st_nxt.status  = flag_nxt;
    st_nxt.link_up = link_up_in;
    if (wr_enable) begin
      st_nxt.enable = reg_wdata & `HISL_ENABLE_MASK;
    end
    if (wr_thresh) begin
      st_nxt.thresh = reg_wdata;
    end
    st_nxt.irq   = |(flag_nxt & st_nxt.enable);
    st_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_W'(`HISL_OFF_STATUS): st_nxt.rdata = st_r.status;
        ADDR_W'(`HISL_OFF_ENABLE): st_nxt.rdata = st_r.enable;
        ADDR_W'(`HISL_OFF_THRESH): st_nxt.rdata = {st_r.thresh[15:8], queue_frame_count};
        default:                   st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // ======================================================================
  // Registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{status: `HISL_STATUS_RST, enable: `HISL_ENABLE_RST,
                thresh: `HISL_THRESH_RST, rdata: 16'h0000, link_up: 1'h0, irq: 1'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq_n     = ~st_r.irq;

  // ======================================================================
  // Checks
  pin_follows_a: assert property (@(posedge clock) disable iff (!arst_n)
    (|(st_r.status & st_r.enable)) |-> !irq_n)
    else $error("pin idle with an enabled flag set");

  read_keeps_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && !reg_wr && !pme_wr) |=>
    ((st_r.status & $past(st_r.status)) == $past(st_r.status)))
    else $error("read cleared a flag");

  w1c_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wr_status && reg_wdata[`HISL_BIT_OVR] && !rx_overrun) |=> !st_r.status[`HISL_BIT_OVR])
    else $error("write one did not clear");

  status_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && hit_status) |=> (reg_rdata == $past(st_r.status)))
    else $error("status read wrong");

  zero_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wr_status && (reg_wdata == 16'h0000) && !pme_wr) |=>
    ((st_r.status & $past(st_r.status)) == $past(st_r.status)))
    else $error("zero write cleared a flag");

  link_edge_a: assert property (@(posedge clock) disable iff (!arst_n)
    $changed(link_up_in) |=> st_r.status[`HISL_BIT_LINK])
    else $error("link change lost");

  txdone_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    tx_frame_done |=> st_r.status[`HISL_BIT_TXDONE])
    else $error("transmit done lost");

  rxready_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    rx_frame_done |=> st_r.status[`HISL_BIT_RXRDY])
    else $error("receive ready lost");

  overrun_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    rx_overrun |=> st_r.status[`HISL_BIT_OVR])
    else $error("overrun lost");

  txstop_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    tx_stopped |=> st_r.status[`HISL_BIT_TXSTOP])
    else $error("transmit stop lost");

  rxstop_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    rx_stopped |=> st_r.status[`HISL_BIT_RXSTOP])
    else $error("receive stop lost");

  space_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    tx_space_avail |=> st_r.status[`HISL_BIT_TXSPACE])
    else $error("transmit space lost");

  wake_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    wake_frame_det |=> st_r.status[`HISL_BIT_WFRAME])
    else $error("wake frame lost");

  wake_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (pme_wr && (pme_event_code == `HISL_PME_WFRAME) && !wake_frame_det) |=>
    !st_r.status[`HISL_BIT_WFRAME])
    else $error("wake frame not cleared");

  wake_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    !pme_wr |=> ((st_r.status & $past(st_r.status) & `HISL_WAKE_MASK)
    == ($past(st_r.status) & `HISL_WAKE_MASK)))
    else $error("wake flag cleared without event code");

  magic_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    magic_det |=> st_r.status[`HISL_BIT_MAGIC])
    else $error("magic flag lost");

  magic_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (pme_wr && (pme_event_code == `HISL_PME_MAGIC) && !magic_det) |=>
    !st_r.status[`HISL_BIT_MAGIC])
    else $error("magic flag not cleared");

  linkup_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    linkup_wake_det |=> st_r.status[`HISL_BIT_LINKUP])
    else $error("link-up wake lost");

  linkup_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (pme_wr && (pme_event_code == `HISL_PME_LINKUP) && !linkup_wake_det) |=>
    !st_r.status[`HISL_BIT_LINKUP])
    else $error("link-up wake not cleared");

  energy_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    energy_det |=> st_r.status[`HISL_BIT_ENERGY])
    else $error("energy wake lost");

  energy_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (pme_wr && (pme_event_code == `HISL_PME_ENERGY) && !energy_det) |=>
    !st_r.status[`HISL_BIT_ENERGY])
    else $error("energy wake not cleared");

  frame_thr_a: assert property (@(posedge clock) disable iff (!arst_n)
    (frame_thr_en && (queue_frame_count >= st_r.thresh[7:0])) |=> st_r.status[`HISL_BIT_RXRDY])
    else $error("frame threshold missed");

  thresh_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_thresh |=> (st_r.thresh == $past(reg_wdata)))
    else $error("threshold write lost");

  byte_thr_a: assert property (@(posedge clock) disable iff (!arst_n)
    (byte_thr_en && (queue_byte_count > BYTE_CNT_W'(st_r.thresh[15:8]))) |=>
    st_r.status[`HISL_BIT_RXRDY])
    else $error("byte threshold missed");

  count_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && hit_thresh) |=> (reg_rdata[7:0] == $past(queue_frame_count)))
    else $error("frame count read wrong");

  enable_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_enable |=> (st_r.enable == ($past(reg_wdata) & `HISL_ENABLE_MASK)))
    else $error("enable write lost");

  enable_mask_a: assert property (@(posedge clock) disable iff (!arst_n)
    ((st_r.enable & ~`HISL_ENABLE_MASK) == 16'h0000))
    else $error("reserved enable bit set");

  reserved_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    ((st_r.status & `HISL_RSVD_MASK) == 16'h0000))
    else $error("reserved status bit set");

  idle_rdata_a: assert property (@(posedge clock) disable iff (!arst_n)
    !reg_rd |=> (reg_rdata == 16'h0000))
    else $error("read data without read");

  unmapped_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && !hit_status && !hit_enable && !hit_thresh) |=> (reg_rdata == 16'h0000))
    else $error("unmapped read not zero");

  pin_release_a: assert property (@(posedge clock) disable iff (!arst_n)
    !(|(st_r.status & st_r.enable)) |-> irq_n)
    else $error("pin stuck");

endmodule // hisl_top

//--- testbench.sv
// Self-checking bench for the host interrupt status logic.
`timescale 1ns/1ns
`include "hisl_cfg.svh"
// ==========
// Bench
module testbench;
  logic        clock = 1'b0, arst_n = 1'b0, link_up_in = 1'b0, pme_wr = 1'b0;
  logic        reg_wr, reg_rd, irq_n, frame_thr_en = 1'b0, byte_thr_en = 1'b0;
  logic [7:0]  reg_addr, queue_frame_count = 8'h00;
  logic [15:0] reg_rdata, reg_wdata, queue_byte_count = 16'h0000, d, e;
  logic [3:0]  pme_event_code = 4'h0;
  logic [9:0]  ev = 10'h000;
  int          num_errors = 0, cmp_count = 0;
  int          bits [10] = '{14, 13, 11, 9, 8, 6, 5, 4, 3, 2};
  initial forever #20 clock = ~clock;
  hisl_host_model host_u (.clock, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  hisl_top dut_u (.clock, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .link_up_in, .tx_frame_done(ev[0]), .rx_frame_done(ev[1]), .rx_overrun(ev[2]),
    .tx_stopped(ev[3]), .rx_stopped(ev[4]), .tx_space_avail(ev[5]), .wake_frame_det(ev[6]),
    .magic_det(ev[7]), .linkup_wake_det(ev[8]), .energy_det(ev[9]), .pme_wr, .pme_event_code,
    .frame_thr_en, .byte_thr_en, .queue_frame_count, .queue_byte_count, .irq_n);
  task automatic chk(string n, logic [15:0] s, logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic st(logic [15:0] x);
    host_u.rd(`HISL_OFF_STATUS, d);
    chk("status", d, x);
  endtask
  task automatic pulse(int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev <= 10'h000;
  endtask
  task automatic pme(logic [3:0] c);
    @(posedge clock);
    pme_wr         <= 1'b1;
    pme_event_code <= c;
    @(posedge clock);
    pme_wr <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    st(16'h0000);
    host_u.rd(`HISL_OFF_THRESH, d);
    chk("thresh", d, 16'h0000);
    host_u.wr(`HISL_OFF_ENABLE, 16'hFFFF);
    host_u.rd(`HISL_OFF_ENABLE, d);
    chk("enable", d, 16'hEB7D);
    host_u.rd(8'h94, d);
    chk("unmapped", d, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      e = 16'h0001 << bits[i];
      pulse(i);
      st(e);
      chk("irq_n", {15'h0000, irq_n}, 16'h0000);
      host_u.wr(`HISL_OFF_STATUS, 16'h0000);
      host_u.wr(`HISL_OFF_STATUS, e);
      st(i < 6 ? 16'h0000 : e);
      if (i > 5) begin
        pme(4'h3);
        pme(4'h1 << (9 - i));
        st(16'h0000);
      end
      chk("irq_n", {15'h0000, irq_n}, 16'h0001);
    end
    $display("test flags done");
    for (int k = 0; k < 2; k++) begin
      link_up_in <= ~link_up_in;
      st(16'h8000);
      host_u.wr(`HISL_OFF_STATUS, 16'h8000);
    end
    $display("test link done");
    host_u.wr(`HISL_OFF_THRESH, 16'h0502);
    frame_thr_en      <= 1'b1;
    queue_frame_count <= 8'h01;
    st(16'h0000);
    host_u.rd(`HISL_OFF_THRESH, d);
    chk("count", d, 16'h0501);
    queue_frame_count <= 8'h02;
    st(16'h2000);
    frame_thr_en     <= 1'b0;
    byte_thr_en      <= 1'b1;
    queue_byte_count <= 16'h0005;
    host_u.wr(`HISL_OFF_STATUS, 16'h2000);
    st(16'h0000);
    queue_byte_count <= 16'h0006;
    st(16'h2000);
    byte_thr_en <= 1'b0;
    host_u.wr(`HISL_OFF_STATUS, 16'h2000);
    $display("test threshold done");
    host_u.wr(`HISL_OFF_ENABLE, 16'h0000);
    pulse(0);
    st(16'h4000);
    chk("irq_n", {15'h0000, irq_n}, 16'h0001);
    $display("test mask done");
    conclude();
  end
endmodule // testbench
